// [osa_datapath.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: any operand, source or destination field may name registers zero to fifteen.
// RULE2: square uses one register twice, only registers four to seven.
// RULE3: multiply pair is two distinct registers from four to seven.
// RULE4: file register operations use register zero as default operand.
// RULE5: x prefetch from reg 8 or 9, indirect, post-modify 2/4/6, indexed, none.
// RULE6: y prefetch from reg 10 or 11 with the same modes.
// RULE7: x fetched data goes to one of registers four to seven.
// RULE8: y fetched data goes to one of registers four to seven.
// RULE9: divide takes dividend and divisor directly from two named registers.
// RULE10: signed add to accumulator adds shifted word; only accumulator flags change.
// RULE11: file add-with-carry sums file, default reg, carry; sets C DC N OV Z.
// RULE12: literal add-with-carry adds ten-bit literal and carry into the register.
// RULE13: shift by register count sign-extends, sets only N and Z.
// RULE14: shift by five-bit literal count behaves alike, N and Z only.
// RULE15: single-bit file shift sets C N OV Z in one cycle.
// RULE16: two accumulators; each accumulator operation names its target.
// RULE17: flags an operation does not list keep their values.
module osa_datapath
  import osa_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          OP_VALID,
  input  wire osa_op_e       OP_CODE,
  input  wire logic [3:0]    OPA_SEL,
  input  wire logic [3:0]    OPB_SEL,
  input  wire logic [3:0]    DEST_SEL,
  input  wire logic          TO_DEFAULT,
  input  wire logic [DW-1:0] FILE_RDATA,
  input  wire logic [DW-1:0] LOAD_DATA,
  input  wire logic [9:0]    TEN_BIT_LITERAL,
  input  wire logic [4:0]    FIVE_BIT_LITERAL,
  input  wire logic [3:0]    ACC_SHIFT,
  input  wire logic          ACC_SEL,
  input  wire osa_pf_e       X_MODE,
  input  wire logic          X_BASE,
  input  wire logic [1:0]    X_DEST,
  input  wire logic [DW-1:0] X_RDATA,
  input  wire osa_pf_e       Y_MODE,
  input  wire logic          Y_BASE,
  input  wire logic [1:0]    Y_DEST,
  input  wire logic [DW-1:0] Y_RDATA,
  input  wire logic [3:0]    PEEK_SEL,
  output logic      [DW-1:0] PEEK_DATA,
  output logic      [DW-1:0] X_ADDR,
  output logic               X_RD,
  output logic      [DW-1:0] Y_ADDR,
  output logic               Y_RD,
  output logic      [DW-1:0] FILE_WDATA,
  output logic               FILE_WE,
  output logic      [DW-1:0] DIV_DIVIDEND,
  output logic      [DW-1:0] DIV_DIVISOR,
  output logic               DIV_VALID,
  output logic               ILLEGAL,
  output logic      [AW-1:0] ACC_A,
  output logic      [AW-1:0] ACC_B,
  output logic               CARRY,
  output logic               DIGIT_CARRY_FLAG,
  output logic               NEG,
  output logic               SIGNED_ERROR_FLAG,
  output logic               ZERO,
  output logic               ACC_A_OVER_FLAG,
  output logic               ACC_B_OVER_FLAG,
  output logic               ACC_A_CLIPPED,
  output logic               ACC_B_CLIPPED
);
  logic [DW-1:0] w_r [NREG];
  logic [DW-1:0] w_nxt [NREG];
  logic [AW-1:0] acc_r [2];
  logic [AW-1:0] acc_nxt [2];
  logic [AW-1:0] acc_sum [2];
  logic [1:0]    ovr_r, ovr_nxt, clip_r, clip_nxt, acc_ovr, acc_clip;
  logic          c_r, dgc_r, n_r, ser_r, z_r;
  logic          c_nxt, dgc_nxt, n_nxt, ser_nxt, z_nxt;
  logic [DW-1:0] fwd_r, fwd_nxt, dvd_r, dvd_nxt, dvs_r, dvs_nxt;
  logic          fwe_r, fwe_nxt, dv_r, dv_nxt, ill_r, ill_nxt;
  logic [DW-1:0] x_upd, y_upd, opa, opb, res;
  logic          x_uwe, y_uwe, x_rd_raw, y_rd_raw;
  logic [3:0]    x_usel, y_usel;
  logic [AW-1:0] addend, wide;
  logic [DW:0]   sum17;
  logic [NIB_BIT:0] nib;
  logic          in_a, in_b, pair_ok, mul_op, acc_op, pf_go, legal;
  logic [31:0]   prod;

  // operand fetch; both selectors reach all sixteen registers
  // RULE1 any of sixteen
  assign opa = w_r[OPA_SEL];
  assign opb = w_r[OPB_SEL];
  assign in_a = (OPA_SEL >= W_MLO) && (OPA_SEL <= W_MHI);
  assign in_b = (OPB_SEL >= W_MLO) && (OPB_SEL <= W_MHI);
  // RULE2 square pair
  // RULE3 multiply pair
  always_comb begin
    pair_ok = in_a && in_b && (OPA_SEL != OPB_SEL);
    if (OP_CODE == OP_SQR) begin
      pair_ok = in_a && (OPA_SEL == OPB_SEL);
    end
  end
  assign mul_op = (OP_CODE == OP_MAC) || (OP_CODE == OP_SQR);
  assign legal  = !mul_op || pair_ok;
  assign acc_op = OP_VALID && legal && (mul_op || OP_CODE == OP_ADD_ACC);
  // prefetch only rides on a legal multiply-class operation
  assign pf_go  = OP_VALID && mul_op && pair_ok;

  // RULE5 x prefetch unit
  osa_pf_agu #(.BASE0(W_X0), .BASE1(W_X1)) u_xagu (
    .pf_mode   (X_MODE),
    .base_pick (X_BASE),
    .w_base0   (w_r[W_X0]),
    .w_base1   (w_r[W_X1]),
    .w_idx     (w_r[W_IDX]),
    .addr      (X_ADDR),
    .rd        (x_rd_raw),
    .upd_val   (x_upd),
    .upd_we    (x_uwe),
    .upd_sel   (x_usel)
  );
  // RULE6 y prefetch unit
  osa_pf_agu #(.BASE0(W_Y0), .BASE1(W_Y1)) u_yagu (
    .pf_mode   (Y_MODE),
    .base_pick (Y_BASE),
    .w_base0   (w_r[W_Y0]),
    .w_base1   (w_r[W_Y1]),
    .w_idx     (w_r[W_IDX]),
    .addr      (Y_ADDR),
    .rd        (y_rd_raw),
    .upd_val   (y_upd),
    .upd_we    (y_uwe),
    .upd_sel   (y_usel)
  );
  assign X_RD = pf_go && x_rd_raw;
  assign Y_RD = pf_go && y_rd_raw;

  // accumulator addend: product or shifted signed word
  always_comb begin
    prod   = 32'($signed(opa)) * 32'($signed(opb));  // widen first, keep all 32 product bits
    wide   = {{(AW-DW-FRAC_SH){opa[DW-1]}}, opa, {FRAC_SH{1'b0}}};
    addend = {{(AW-32){prod[31]}}, prod};
    if (OP_CODE == OP_ADD_ACC) begin
      // RULE10 positive count shifts right, negative left
      if (ACC_SHIFT[SW-1]) begin
        addend = wide << (~ACC_SHIFT + 4'h1);
      end else begin
        addend = AW'($signed(wide) >>> ACC_SHIFT);
      end
    end
  end

  // RULE16 one adder per accumulator
  for (genvar i = 0; i < 2; i++) begin : g_acc
    osa_acc_add u_add (
      .acc_q  (acc_r[i]),
      .addend (addend),
      .sum    (acc_sum[i]),
      .over   (acc_ovr[i]),
      .clip   (acc_clip[i])
    );
    // only the named accumulator and its own flags move
    always_comb begin
      acc_nxt[i]  = acc_r[i];
      ovr_nxt[i]  = ovr_r[i];
      clip_nxt[i] = clip_r[i];
      if (acc_op && (ACC_SEL == 1'(i))) begin
        acc_nxt[i]  = acc_sum[i];
        ovr_nxt[i]  = acc_ovr[i];
        clip_nxt[i] = clip_r[i] | acc_clip[i];  // saturate flag is sticky
      end
    end
  end

  // carry-chain add shared by both add-with-carry forms
  always_comb begin
    if (OP_CODE == OP_AWC_L) begin
      sum17 = {1'b0, opa} + {7'h00, TEN_BIT_LITERAL} + {16'h0000, c_r};
      nib   = {1'b0, opa[3:0]} + {1'b0, TEN_BIT_LITERAL[3:0]} + {4'h0, c_r};
    end else begin
      sum17 = {1'b0, FILE_RDATA} + {1'b0, w_r[W_DEF]} + {16'h0000, c_r};
      nib   = {1'b0, FILE_RDATA[3:0]} + {1'b0, w_r[W_DEF][3:0]} + {4'h0, c_r};
    end
  end

  // working registers, mcu flags and side outputs
  always_comb begin
    w_nxt   = w_r;
    c_nxt   = c_r;
    dgc_nxt = dgc_r;
    n_nxt   = n_r;
    ser_nxt = ser_r;
    z_nxt   = z_r;
    fwd_nxt = fwd_r;
    fwe_nxt = 1'b0;
    dvd_nxt = dvd_r;
    dvs_nxt = dvs_r;
    dv_nxt  = 1'b0;
    ill_nxt = OP_VALID && !legal;
    res     = W_RST;
    if (OP_VALID) begin
      unique case (OP_CODE)
        OP_LOAD: w_nxt[DEST_SEL] = LOAD_DATA;
        OP_AWC_F, OP_AWC_L: begin
          // RULE11 file form; RULE12 literal form
          res    = sum17[DW-1:0];
          c_nxt  = sum17[DW];
          dgc_nxt = nib[NIB_BIT];
          n_nxt  = res[DW-1];
          if (OP_CODE == OP_AWC_L) begin
            ser_nxt = !opa[DW-1] && res[DW-1];
          end else begin
            ser_nxt = (FILE_RDATA[DW-1] == w_r[W_DEF][DW-1])
                     && (res[DW-1] != FILE_RDATA[DW-1]);
          end
          z_nxt  = z_r && (res == W_RST);   // zero is sticky on carry adds
          if (OP_CODE == OP_AWC_L) begin
            w_nxt[OPA_SEL] = res;
          // RULE4 default operand is register zero
          end else if (TO_DEFAULT) begin
            w_nxt[W_DEF] = res;
          end else begin
            fwd_nxt = res;
            fwe_nxt = 1'b1;
          end
        end
        OP_SRA_F: begin
          // RULE15 one-place shift of the file word
          res    = {FILE_RDATA[DW-1], FILE_RDATA[DW-1:1]};
          c_nxt  = FILE_RDATA[0];
          n_nxt  = res[DW-1];
          ser_nxt = 1'b0;
          z_nxt  = res == W_RST;
          if (TO_DEFAULT) begin
            w_nxt[W_DEF] = res;
          end else begin
            fwd_nxt = res;
            fwe_nxt = 1'b1;
          end
        end
        OP_SRA_R, OP_SRA_L: begin
          // RULE13 count from a register; RULE14 from the literal
          if (OP_CODE == OP_SRA_R) begin
            res = DW'($signed(opa) >>> opb[3:0]);
          end else begin
            res = DW'($signed(opa) >>> FIVE_BIT_LITERAL);
          end
          n_nxt = res[DW-1];
          z_nxt = res == W_RST;
          w_nxt[DEST_SEL] = res;
        end
        OP_MAC, OP_SQR: begin
          if (pair_ok) begin
            // base updates first; a fetched word landing on them wins
            if (X_RD && x_uwe) begin
              w_nxt[x_usel] = x_upd;
            end
            if (Y_RD && y_uwe) begin
              w_nxt[y_usel] = y_upd;
            end
            // RULE7 x data to four..seven
            if (X_RD) begin
              w_nxt[W_MLO + {2'b00, X_DEST}] = X_RDATA;
            end
            // RULE8 y data to four..seven
            if (Y_RD) begin
              w_nxt[W_MLO + {2'b00, Y_DEST}] = Y_RDATA;
            end
          end
        end
        OP_DIV: begin
          // RULE9 operands named directly
          dvd_nxt = opa;
          dvs_nxt = opb;
          dv_nxt  = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // RULE17 flags only move where an operation assigns them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int k = 0; k < NREG; k++) w_r[k] <= W_RST;
      acc_r[0] <= ACC_RST;
      acc_r[1] <= ACC_RST;
      {c_r, dgc_r, n_r, ser_r, z_r} <= 5'h00;
      ovr_r   <= 2'h0;
      clip_r  <= 2'h0;
      fwd_r   <= W_RST;
      fwe_r   <= 1'b0;
      dvd_r   <= W_RST;
      dvs_r   <= W_RST;
      dv_r    <= 1'b0;
      ill_r   <= 1'b0;
    end else begin
      w_r     <= w_nxt;
      acc_r   <= acc_nxt;
      {c_r, dgc_r, n_r, ser_r, z_r} <= {c_nxt, dgc_nxt, n_nxt, ser_nxt, z_nxt};
      ovr_r   <= ovr_nxt;
      clip_r  <= clip_nxt;
      fwd_r   <= fwd_nxt;
      fwe_r   <= fwe_nxt;
      dvd_r   <= dvd_nxt;
      dvs_r   <= dvs_nxt;
      dv_r    <= dv_nxt;
      ill_r   <= ill_nxt;
    end
  end

  assign PEEK_DATA         = w_r[PEEK_SEL];
  assign FILE_WDATA        = fwd_r;
  assign FILE_WE           = fwe_r;
  assign DIV_DIVIDEND      = dvd_r;
  assign DIV_DIVISOR       = dvs_r;
  assign DIV_VALID         = dv_r;
  assign ILLEGAL           = ill_r;
  assign ACC_A             = acc_r[0];
  assign ACC_B             = acc_r[1];
  assign CARRY             = c_r;
  assign DIGIT_CARRY_FLAG  = dgc_r;
  assign NEG               = n_r;
  assign SIGNED_ERROR_FLAG = ser_r;
  assign ZERO              = z_r;
  assign ACC_A_OVER_FLAG   = ovr_r[0];
  assign ACC_B_OVER_FLAG   = ovr_r[1];
  assign ACC_A_CLIPPED     = clip_r[0];
  assign ACC_B_CLIPPED     = clip_r[1];

  // checks on the operation effects
  a_sqr_pair_bad: assert property (@(posedge CLK) disable iff (RST) // RULE2
    OP_VALID && OP_CODE == OP_SQR && OPA_SEL != OPB_SEL |=> ILLEGAL && $stable(ACC_A))
    else $error("bad square pair not refused");
  a_mac_pair_bad: assert property (@(posedge CLK) disable iff (RST) // RULE3
    OP_VALID && OP_CODE == OP_MAC && !(in_a && in_b) |-> !X_RD && !Y_RD ##1 ILLEGAL)
    else $error("bad multiply pair not refused");
  a_x_idx_addr: assert property (@(posedge CLK) disable iff (RST) // RULE5
    X_RD && X_MODE == PF_IDX |-> X_ADDR == w_r[X_BASE ? W_X1 : W_X0] + w_r[W_IDX])
    else $error("x indexed address wrong");
  a_y_inc_base: assert property (@(posedge CLK) disable iff (RST) // RULE6
    Y_RD && Y_MODE == PF_INC6 |=>
      w_r[$past(Y_BASE) ? W_Y1 : W_Y0] == $past(Y_ADDR) + STEP6)
    else $error("y post-increment wrong");
  a_x_dest_load: assert property (@(posedge CLK) disable iff (RST) // RULE7
    X_RD && !Y_RD |=> w_r[W_MLO + {2'b00, $past(X_DEST)}] == $past(X_RDATA))
    else $error("x data not stored");
  a_div_direct: assert property (@(posedge CLK) disable iff (RST) // RULE9
    OP_VALID && OP_CODE == OP_DIV |=> DIV_VALID && DIV_DIVISOR == $past(opb)
      && DIV_DIVIDEND == $past(opa) ##1 (!DIV_VALID || $past(OP_VALID && OP_CODE == OP_DIV)))
    else $error("divide operands wrong");
  a_acc_mcu_hold: assert property (@(posedge CLK) disable iff (RST) // RULE10
    OP_VALID && OP_CODE == OP_ADD_ACC |=> $stable({CARRY, NEG, ZERO, SIGNED_ERROR_FLAG}))
    else $error("acc add touched mcu flags");
  a_add_with_carry_op_file: assert property (@(posedge CLK) disable iff (RST) // RULE11
    OP_VALID && OP_CODE == OP_AWC_F && TO_DEFAULT |=>
      {CARRY, w_r[W_DEF]} == $past(sum17))
    else $error("file add-with-carry wrong");
  a_asr_nz_only: assert property (@(posedge CLK) disable iff (RST) // RULE13
    OP_VALID && (OP_CODE == OP_SRA_R || OP_CODE == OP_SRA_L) |=>
      $stable(CARRY) && $stable(SIGNED_ERROR_FLAG) && NEG == w_r[$past(DEST_SEL)][DW-1])
    else $error("shift flags wrong");
  a_asr_f_carry: assert property (@(posedge CLK) disable iff (RST) // RULE15
    OP_VALID && OP_CODE == OP_SRA_F |=> CARRY == $past(FILE_RDATA[0]) && !SIGNED_ERROR_FLAG)
    else $error("single shift flags wrong");
  a_acc_other: assert property (@(posedge CLK) disable iff (RST) // RULE16
    OP_VALID && OP_CODE == OP_ADD_ACC && !ACC_SEL |=> $stable(ACC_B) && $stable(ACC_B_CLIPPED))
    else $error("wrong accumulator moved");
endmodule : osa_datapath

// [osa_pkg.sv]
package osa_pkg;
  // widths and counts
  localparam int DW      = 16;
  localparam int NREG    = 16;
  localparam int AW      = 40;
  localparam int SW      = 4;
  localparam int FRAC_SH = 16;   // word lands in acc bits 31:16
  localparam int NIB_BIT = 4;    // digit carry is carry out of bit 3
  // fixed register roles
  localparam logic [3:0] W_DEF = 4'h0;
  localparam logic [3:0] W_X0  = 4'h8;
  localparam logic [3:0] W_X1  = 4'h9;
  localparam logic [3:0] W_Y0  = 4'hA;
  localparam logic [3:0] W_Y1  = 4'hB;
  localparam logic [3:0] W_IDX = 4'hC;
  localparam logic [3:0] W_MLO = 4'h4;
  localparam logic [3:0] W_MHI = 4'h7;
  localparam logic [DW-1:0] STEP2 = 16'h0002;
  localparam logic [DW-1:0] STEP4 = 16'h0004;
  localparam logic [DW-1:0] STEP6 = 16'h0006;
  localparam logic [DW-1:0] W_RST = 16'h0000;
  localparam logic [AW-1:0] ACC_RST = 40'h00_0000_0000;
  // operations the decoder may issue
  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_AWC_F, OP_AWC_L, OP_SRA_F, OP_SRA_R,
    OP_SRA_L, OP_ADD_ACC, OP_MAC, OP_SQR, OP_DIV
  } osa_op_e;
  // prefetch address modes
  typedef enum logic [3:0] {
    PF_NONE, PF_IND, PF_INC2, PF_INC4, PF_INC6,
    PF_DEC2, PF_DEC4, PF_DEC6, PF_IDX
  } osa_pf_e;
endpackage : osa_pkg

// [osa_pf_agu.sv]
`timescale 1ns/1ps
module osa_pf_agu
  import osa_pkg::*;
#(
  parameter logic [3:0] BASE0 = W_X0,
  parameter logic [3:0] BASE1 = W_X1
) (
  input  wire osa_pf_e         pf_mode,
  input  wire logic            base_pick,
  input  wire logic [DW-1:0]   w_base0,
  input  wire logic [DW-1:0]   w_base1,
  input  wire logic [DW-1:0]   w_idx,
  output logic      [DW-1:0]   addr,
  output logic                 rd,
  output logic      [DW-1:0]   upd_val,
  output logic                 upd_we,
  output logic      [3:0]      upd_sel
);
  logic [DW-1:0] base;

  // address from the chosen base, post-modify written back afterwards
  always_comb begin
    base    = base_pick ? w_base1 : w_base0;
    upd_sel = base_pick ? BASE1 : BASE0;
    addr    = base;
    rd      = 1'b1;
    upd_we  = 1'b1;
    upd_val = base;
    unique case (pf_mode)
      PF_NONE: begin
        rd     = 1'b0;
        upd_we = 1'b0;
      end
      PF_IND:  upd_we = 1'b0;
      PF_INC2: upd_val = base + STEP2;
      PF_INC4: upd_val = base + STEP4;
      PF_INC6: upd_val = base + STEP6;
      PF_DEC2: upd_val = base - STEP2;
      PF_DEC4: upd_val = base - STEP4;
      PF_DEC6: upd_val = base - STEP6;
      PF_IDX: begin
        addr   = base + w_idx;   // index never modifies the base
        upd_we = 1'b0;
      end
      default: begin
        rd     = 1'b0;
        upd_we = 1'b0;
      end
    endcase
  end
endmodule : osa_pf_agu

// [osa_acc_add.sv]
`timescale 1ns/1ps
module osa_acc_add
  import osa_pkg::*;
(
  input  wire logic [AW-1:0] acc_q,
  input  wire logic [AW-1:0] addend,
  output logic      [AW-1:0] sum,
  output logic               over,
  output logic               clip
);
  logic [AW:0] ext;

  // add with one guard bit, clamp on full-width overflow
  always_comb begin
    ext  = {acc_q[AW-1], acc_q} + {addend[AW-1], addend};
    clip = ext[AW] != ext[AW-1];
    if (clip) begin
      sum = ext[AW] ? {1'b1, {(AW-1){1'b0}}} : {1'b0, {(AW-1){1'b1}}};
    end else begin
      sum = ext[AW-1:0];
    end
    // guard bits in use: result no longer fits 32 bits
    over = !((&sum[AW-1:31]) || !(|sum[AW-1:31]));
  end
endmodule : osa_acc_add

// [osa_mem_port.sv]
`timescale 1ns/1ps
// one prefetch data space, answering in the same cycle as the address
module osa_mem_port
  import osa_pkg::*;
#(
  parameter logic [DW-1:0] PAT = 16'h5A3C
) (
  input  wire logic          clk,
  input  wire logic [DW-1:0] addr,
  input  wire logic          rd,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] last_r = 16'h0000;
  // an idle bus flips every cycle so that stale data can never pass for a fetch
  always_ff @(posedge clk) begin
    last_r <= rdata;
  end
  assign rdata = rd ? (addr ^ PAT) : ~last_r;
endmodule : osa_mem_port

// [operand_select_alu_datapath_tb_top.sv]
`timescale 1ns/1ps
module operand_select_alu_datapath_tb_top
  import osa_pkg::*;
;
  localparam logic [DW-1:0] XP = 16'h5A3C;
  localparam logic [DW-1:0] YP = 16'hC3A5;
  logic CLK, RST, OP_VALID, TO_DEFAULT, ACC_SEL, X_BASE, Y_BASE, X_RD, Y_RD;
  logic FILE_WE, DIV_VALID, ILLEGAL, CARRY, DIGIT_CARRY_FLAG, NEG, SIGNED_ERROR_FLAG, ZERO;
  logic ACC_A_OVER_FLAG, ACC_B_OVER_FLAG, ACC_A_CLIPPED, ACC_B_CLIPPED;
  osa_op_e OP_CODE;
  osa_pf_e X_MODE, Y_MODE;
  logic [3:0] OPA_SEL, OPB_SEL, DEST_SEL, ACC_SHIFT, PEEK_SEL;
  logic [1:0] X_DEST, Y_DEST;
  logic [9:0] TEN_BIT_LITERAL;
  logic [4:0] FIVE_BIT_LITERAL;
  logic [DW-1:0] FILE_RDATA, LOAD_DATA, X_RDATA, Y_RDATA, PEEK_DATA, X_ADDR, Y_ADDR;
  logic [DW-1:0] FILE_WDATA, DIV_DIVIDEND, DIV_DIVISOR;
  logic [AW-1:0] ACC_A, ACC_B;
  // the bench's own picture of registers, accumulators and flags
  logic [DW-1:0] wm [NREG];
  logic [AW-1:0] am [2];
  logic cy, dcy, ng, serr, zr, xrd, yrd;
  logic [DW-1:0] xad, yad;
  int failures;
  int total_checks;

  osa_datapath u_dut (
    .CLK, .RST, .OP_VALID, .OP_CODE, .OPA_SEL, .OPB_SEL, .DEST_SEL, .TO_DEFAULT,
    .FILE_RDATA, .LOAD_DATA, .TEN_BIT_LITERAL, .FIVE_BIT_LITERAL, .ACC_SHIFT, .ACC_SEL,
    .X_MODE, .X_BASE, .X_DEST, .X_RDATA, .Y_MODE, .Y_BASE, .Y_DEST, .Y_RDATA,
    .PEEK_SEL, .PEEK_DATA, .X_ADDR, .X_RD, .Y_ADDR, .Y_RD, .FILE_WDATA, .FILE_WE,
    .DIV_DIVIDEND, .DIV_DIVISOR, .DIV_VALID, .ILLEGAL, .ACC_A, .ACC_B, .CARRY,
    .DIGIT_CARRY_FLAG, .NEG, .SIGNED_ERROR_FLAG, .ZERO, .ACC_A_OVER_FLAG,
    .ACC_B_OVER_FLAG, .ACC_A_CLIPPED, .ACC_B_CLIPPED
  );
  osa_mem_port #(.PAT(XP)) u_xmem (.clk(CLK), .addr(X_ADDR), .rd(X_RD), .rdata(X_RDATA));
  osa_mem_port #(.PAT(YP)) u_ymem (.clk(CLK), .addr(Y_ADDR), .rd(Y_RD), .rdata(Y_RDATA));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // every comparison funnels through here
  task automatic cmpa(input logic [AW-1:0] g, input logic [AW-1:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmpa
  task automatic cmpw(input logic [DW-1:0] g, input logic [DW-1:0] e);
    cmpa({24'h0, g}, {24'h0, e});
  endtask : cmpw
  task automatic cmpf(input logic g, input logic e);
    cmpa({39'h0, g}, {39'h0, e});
  endtask : cmpf

  task automatic close_out();
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // guard bits in use means the accumulator left its fractional range
  function automatic logic gd(input logic [AW-1:0] a);
    return !((&a[39:31]) || !(|a[39:31]));
  endfunction : gd

  function automatic logic [DW-1:0] dl(input osa_pf_e m);
    case (m)
      PF_INC2: return STEP2;
      PF_INC4: return STEP4;
      PF_INC6: return STEP6;
      PF_DEC2: return -STEP2;
      PF_DEC4: return -STEP4;
      PF_DEC6: return -STEP6;
      default: return 16'h0000;
    endcase
  endfunction : dl

  // add with carry; zero is sticky, so these adds can clear it but never set it
  function automatic logic [DW-1:0] addm(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic [DW:0] s;
    logic [4:0] q;
    s = a + b + cy;
    q = a[3:0] + b[3:0] + cy;
    serr = (a[15] == b[15]) && (s[15] != a[15]);
    cy = s[16];
    dcy = q[4];
    ng = s[15];
    zr = zr && (s[15:0] == 16'h0000);
    return s[15:0];
  endfunction : addm

  // the strobe drops first so no operation repeats while the peek port sweeps
  task automatic chk_state();
    OP_VALID = 1'b0;
    cmpa({31'h0, CARRY, DIGIT_CARRY_FLAG, NEG, SIGNED_ERROR_FLAG, ZERO, ACC_A_OVER_FLAG,
          ACC_B_OVER_FLAG, ACC_A_CLIPPED, ACC_B_CLIPPED},
         {31'h0, cy, dcy, ng, serr, zr, gd(am[0]), gd(am[1]), 2'b00});
    cmpa(ACC_A, am[0]);
    cmpa(ACC_B, am[1]);
    for (int r = 0; r < NREG; r++) begin
      PEEK_SEL = 4'(r);
      @(negedge CLK);
      cmpw(PEEK_DATA, wm[r]);
    end
  endtask : chk_state

  // the strobe stays up so a following call issues back to back
  task automatic go(input osa_op_e o);
    OP_CODE = o;
    OP_VALID = 1'b1;
    #1;
    xrd = X_RD;
    xad = X_ADDR;
    yrd = Y_RD;
    yad = Y_ADDR;
    @(negedge CLK);
  endtask : go
  task automatic idle();
    OP_VALID = 1'b0;
    @(negedge CLK);
  endtask : idle
  task automatic ld(input logic [3:0] r, input logic [DW-1:0] v);
    DEST_SEL = r;
    LOAD_DATA = v;
    go(OP_LOAD);
    wm[r] = v;
  endtask : ld

  task automatic t_regs();
    for (int r = 0; r < NREG; r++) begin
      ld(4'(r), {4'(r), 4'hC, ~4'(r), 4'h3});
    end
    chk_state();
  endtask : t_regs

  task automatic t_carry_sum();
    ld(4'h3, 16'h7FFF);
    ld(W_DEF, 16'h0001);
    FILE_RDATA = 16'hFFFF;
    TO_DEFAULT = 1'b1;
    go(OP_AWC_F);
    wm[0] = addm(16'hFFFF, wm[0]);
    chk_state();
    OPA_SEL = 4'h3;
    TEN_BIT_LITERAL = 10'h3FF;
    go(OP_AWC_L);
    wm[3] = addm(16'h03FF, wm[3]);
    chk_state();
    ld(W_DEF, 16'h8000);
    FILE_RDATA = 16'h8000;
    TO_DEFAULT = 1'b0;
    go(OP_AWC_F);
    cmpf(FILE_WE, 1'b1);
    cmpw(FILE_WDATA, addm(16'h8000, wm[0]));
    chk_state();
    idle();
    cmpf(FILE_WE, 1'b0);
  endtask : t_carry_sum

  // carry and signed error are left set beforehand so a stray clear shows
  task automatic t_shift_right();
    ld(4'h2, 16'h8000);
    ld(4'h5, 16'h0014);
    OPA_SEL = 4'h2;
    OPB_SEL = 4'h5;
    DEST_SEL = 4'h9;
    go(OP_SRA_R);
    wm[9] = 16'hF800;
    ng = 1'b1;
    chk_state();
    ld(4'h3, 16'h4000);
    OPA_SEL = 4'h3;
    DEST_SEL = 4'hA;
    FIVE_BIT_LITERAL = 5'h1F;
    go(OP_SRA_L);
    wm[10] = 16'h0000;
    ng = 1'b0;
    zr = 1'b1;
    chk_state();
    OPA_SEL = 4'h2;
    DEST_SEL = 4'hF;
    go(OP_SRA_L);
    wm[15] = 16'hFFFF;
    ng = 1'b1;
    zr = 1'b0;
    chk_state();
    FILE_RDATA = 16'h8001;
    TO_DEFAULT = 1'b1;
    go(OP_SRA_F);
    wm[0] = 16'hC000;
    serr = 1'b0;
    chk_state();
    FILE_RDATA = 16'h0002;
    TO_DEFAULT = 1'b0;
    go(OP_SRA_F);
    cmpw(FILE_WDATA, 16'h0001);
    cy = 1'b0;
    ng = 1'b0;
    chk_state();
  endtask : t_shift_right

  // one multiply class op; refused pairs must leave every register alone
  task automatic dsp(input osa_op_e o, input logic [3:0] a, input logic [3:0] b,
                     input logic s, input osa_pf_e xm, input osa_pf_e ym,
                     input logic [1:0] k);
    logic ok;
    logic [31:0] p;
    logic [DW-1:0] xe;
    logic [DW-1:0] ye;
    ok = (a[3:2] == 2'b01) && (b[3:2] == 2'b01) && ((o == OP_SQR) == (a == b));
    OPA_SEL = a;
    OPB_SEL = b;
    ACC_SEL = s;
    X_MODE = xm;
    Y_MODE = ym;
    X_BASE = k[0];
    Y_BASE = k[1];
    X_DEST = k;
    Y_DEST = ~k;
    xe = wm[{3'b100, k[0]}] + ((xm == PF_IDX) ? wm[12] : 16'h0000);
    ye = wm[{3'b101, k[1]}] + ((ym == PF_IDX) ? wm[12] : 16'h0000);
    p = $signed(wm[a]) * $signed(wm[b]);
    go(o);
    cmpf(ILLEGAL, !ok);
    cmpf(xrd, ok && xm != PF_NONE);
    cmpf(yrd, ok && ym != PF_NONE);
    if (ok) begin
      am[s] = am[s] + {{8{p[31]}}, p};
      if (xm != PF_NONE) begin
        cmpw(xad, xe);
        wm[{3'b100, k[0]}] += dl(xm);
        wm[{2'b01, k}] = xe ^ XP;
      end
      if (ym != PF_NONE) begin
        cmpw(yad, ye);
        wm[{3'b101, k[1]}] += dl(ym);
        wm[{2'b01, ~k}] = ye ^ YP;
      end
    end
    chk_state();
  endtask : dsp

  task automatic t_dsp();
    logic [3:0] pa [6] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
    logic [3:0] pb [6] = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
    for (int r = 4; r < 13; r++) begin
      ld(4'(r), {4'(r), 12'h0F2});
    end
    for (int i = 0; i < 9; i++) begin
      dsp(OP_MAC, pa[i % 6], pb[i % 6], i[0], osa_pf_e'(i), osa_pf_e'(8 - i), 2'(i));
    end
    for (int r = 4; r < 8; r++) begin
      dsp(OP_SQR, 4'(r), 4'(r), r[1], PF_INC4, PF_DEC2, 2'(r));
    end
    dsp(OP_MAC, 4'h4, 4'h4, 1'b0, PF_INC2, PF_INC2, 2'h0);
    dsp(OP_MAC, 4'h3, 4'h5, 1'b1, PF_IND, PF_IND, 2'h1);
    dsp(OP_SQR, 4'h4, 4'h5, 1'b0, PF_INC2, PF_DEC2, 2'h2);
    dsp(OP_SQR, 4'h8, 4'h8, 1'b1, PF_IDX, PF_IDX, 2'h3);
    idle();
    cmpf(ILLEGAL, 1'b0);
  endtask : t_dsp

  task automatic t_div();
    OPA_SEL = 4'h1;
    OPB_SEL = 4'hF;
    go(OP_DIV);
    cmpf(DIV_VALID, 1'b1);
    cmpw(DIV_DIVIDEND, wm[1]);
    cmpw(DIV_DIVISOR, wm[15]);
    OPA_SEL = 4'hF;
    OPB_SEL = 4'h1;
    go(OP_DIV);
    cmpw(DIV_DIVIDEND, wm[15]);
    cmpw(DIV_DIVISOR, wm[1]);
    idle();
    cmpf(DIV_VALID, 1'b0);
    chk_state();
  endtask : t_div

  // word enters at bits 31:16; a negative shift code means a left shift
  task automatic accadd(input logic [3:0] r, input logic [3:0] sh, input logic s);
    logic signed [AW-1:0] v;
    OPA_SEL = r;
    OPB_SEL = r;
    ACC_SHIFT = sh;
    ACC_SEL = s;
    v = {{8{wm[r][15]}}, wm[r], 16'h0000};
    v = sh[3] ? (v <<< (5'd16 - sh)) : (v >>> sh);
    go(OP_ADD_ACC);
    am[s] = am[s] + v;
    chk_state();
  endtask : accadd

  task automatic t_acc();
    ld(4'h1, 16'h7FFF);
    accadd(4'h1, 4'h0, 1'b0);
    accadd(4'h1, 4'hF, 1'b0);
    accadd(4'h2, 4'h3, 1'b1);
    accadd(4'h1, 4'hC, 1'b1);
  endtask : t_acc

  // main sequence; inputs change only at falling edges
  initial begin
    {RST, OP_VALID, TO_DEFAULT, ACC_SEL, X_BASE, Y_BASE} = 6'b100000;
    {OPA_SEL, OPB_SEL, DEST_SEL, ACC_SHIFT, PEEK_SEL, X_DEST, Y_DEST} = '0;
    {FILE_RDATA, LOAD_DATA, TEN_BIT_LITERAL, FIVE_BIT_LITERAL} = '0;
    OP_CODE = OP_NOP;
    X_MODE = PF_NONE;
    Y_MODE = PF_NONE;
    {cy, dcy, ng, serr, zr} = 5'b00000;
    wm = '{default: W_RST};
    am = '{default: ACC_RST};
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    chk_state();
    t_regs();
    t_carry_sum();
    t_shift_right();
    t_dsp();
    t_div();
    t_acc();
    idle();
    close_out();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #50000;
    failures++;
    close_out();
  end
endmodule : operand_select_alu_datapath_tb_top
